// ===== pwr_clk_ctrl.sv
// Power-down, idle and AHB clock-gating controller with a Wishbone slave.
// Assumes the core pulses i_sleep_req on a wait instruction and sources pulse wake events.
// What this block does
// - Arm bit with deep sleep picks power-down, else idle
// - Wake-up from power-down sets the wake flag
// - Writing one clears flag, zero ignored
// - Flag works only with interrupt enable set
// - Interrupt when flag and enable high
// - Wake delay 4096 crystal, 256 RC
// - Slow RC enable turns oscillator on
// - Fast RC enable turns oscillator on
// - Crystal pin select has four encodings
// - Idle stops only CPU clock
// - Normal run: clocks follow registers
// - Deep sleep plus arm gives power-down
// - AHB gate bit four drives divider clock
// - AHB gate bit two drives flash clock
// - Protected bits need unlock first
// - Arm bit clears on power-down wake
// - Power-down stops fast oscillators, slow optional
//
// Added by the designer: the Wishbone interface to the registers.
module pwr_clk_ctrl
    import pwr_clk_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire pwr_clk_pkg::wb_req_type i_wb,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    input wire logic i_sleep_req,
    input wire logic i_wake_evt,
    input wire logic i_sysclk_from_fast_xtal,
    output logic o_cpu_clk_en,
    output logic o_divider_unit_clk_en,
    output logic o_flash_prog_clk_en,
    output pwr_clk_pkg::osc_ctl_type o_osc,
    output logic o_fast_periph_clk_en,
    output logic o_wake_irq
);
    import pwr_clk_pkg::*;

    logic [31:0] pwrctl_ff;
    logic [31:0] ahbclk_ff;
    logic sysctl_deep_ff;
    logic [1:0] unlock_step_ff;
    logic unlocked_ff;
    logic [12:0] dly_cnt_ff;
    logic ack_ff;
    logic [31:0] rdat_ff;
    pm_state_type state_ff;
    pm_state_type nxt_state;
    logic cpu_en_ff, div_en_ff, isp_en_ff, irq_ff, fast_periph_ff;
    osc_ctl_type osc_ff;

    // Bus decode: one answer per request, ack drops the cycle after
    wire req = i_wb.cyc & i_wb.stb & ~ack_ff;
    wire wr = req & i_wb.we & i_wb.sel[0];
    wire wr_hi = req & i_wb.we & i_wb.sel[1];
    wire wr_pwr = wr & (i_wb.adr == ADDR_PWRCTL);
    wire wr_ahb = wr & (i_wb.adr == ADDR_AHBCLK);
    wire wr_key = wr & (i_wb.adr == ADDR_UNLOCK);
    wire wr_sys = wr & (i_wb.adr == ADDR_SYSCTL);
    wire [31:0] rd_mux = (i_wb.adr == ADDR_PWRCTL) ? pwrctl_ff :
                         (i_wb.adr == ADDR_AHBCLK) ? ahbclk_ff :
                         (i_wb.adr == ADDR_UNLOCK) ? {31'h00000000, unlocked_ff} :
                         (i_wb.adr == ADDR_SYSCTL) ? {29'h00000000, sysctl_deep_ff, 2'h0} : 32'h00000000;

    // Power-down is chosen only with deep sleep and arm both set
    wire pd_go = sysctl_deep_ff & pwrctl_ff[BIT_POWER_DOWN_ARM];
    wire [1:0] xtl = pwrctl_ff[1:0];
    wire in_pd = (state_ff == ST_PDOWN);
    wire wake_from_pd = in_pd & i_wake_evt;
    // Flag is only set while its interrupt enable is on; set wins over clear
    wire set_flag = wake_from_pd & pwrctl_ff[BIT_WKIEN];
    wire clr_flag = wr_pwr & i_wb.dat[BIT_WKIF];
    wire [12:0] dly_load = i_sysclk_from_fast_xtal ? DLY_FAST_XTAL_CNT : DLY_FAST_RC_CNT;
    wire [31:0] wmask = unlocked_ff ? PWRCTL_WMASK : 32'h00000000;
    wire [31:0] bytemask = {16'h0000, {8{wr_hi}}, {8{1'b1}}};
    wire [31:0] pwr_wr_val = (pwrctl_ff & ~(wmask & bytemask)) | (i_wb.dat & wmask & bytemask);

    // Sleep sequencer
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            ST_RUN:
            begin
                if (i_sleep_req)
                    nxt_state = pd_go ? ST_PDOWN : ST_IDLE;
            end
            ST_IDLE:
            begin
                if (i_wake_evt)
                    nxt_state = ST_RUN;
            end
            ST_PDOWN:
            begin
                if (i_wake_evt)
                    nxt_state = pwrctl_ff[BIT_WKDLY] ? ST_WAKE : ST_RUN;
            end
            ST_WAKE:
            begin
                if (dly_cnt_ff == 13'h0001)
                    nxt_state = ST_RUN;
            end
            default: nxt_state = ST_RUN;
        endcase
    end

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
            state_ff <= ST_RUN;
        else
            state_ff <= nxt_state;
    end

    // Stabilisation counter loaded on wake
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
            dly_cnt_ff <= 13'h0000;
        else if (wake_from_pd)
            dly_cnt_ff <= dly_load;
        else if (dly_cnt_ff != 13'h0000)
            dly_cnt_ff <= dly_cnt_ff - 13'h0001;
    end

    // Unlock key sequencer; a wrong byte restarts it
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            unlock_step_ff <= 2'h0;
            unlocked_ff <= 1'b0;
        end
        else if (wr_key)
        begin
            if (unlock_step_ff == 2'h0 && i_wb.dat[7:0] == UNLOCK_KEY0)
                unlock_step_ff <= 2'h1;
            else if (unlock_step_ff == 2'h1 && i_wb.dat[7:0] == UNLOCK_KEY1)
                unlock_step_ff <= 2'h2;
            else if (unlock_step_ff == 2'h2 && i_wb.dat[7:0] == UNLOCK_KEY2)
            begin
                unlock_step_ff <= 2'h0;
                unlocked_ff <= 1'b1;
            end
            else
            begin
                unlock_step_ff <= 2'h0;
                unlocked_ff <= 1'b0;
            end
        end
    end

    // Power-down control register
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
            pwrctl_ff <= PWRCTL_RESET;
        else
        begin
            if (wr_pwr)
                pwrctl_ff <= pwr_wr_val;
            if (wake_from_pd)
                pwrctl_ff[BIT_POWER_DOWN_ARM] <= 1'b0;
            if (set_flag)
                pwrctl_ff[BIT_WKIF] <= 1'b1;
            else if (clr_flag)
                pwrctl_ff[BIT_WKIF] <= 1'b0;
            else
                pwrctl_ff[BIT_WKIF] <= pwrctl_ff[BIT_WKIF];
        end
    end

    // AHB gates and system control; not write protected
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            ahbclk_ff <= AHBCLK_RESET;
            sysctl_deep_ff <= 1'b0;
        end
        else
        begin
            if (wr_ahb)
                ahbclk_ff <= i_wb.dat & AHBCLK_MASK;
            if (wr_sys)
                sysctl_deep_ff <= i_wb.dat[BIT_DEEP];
        end
    end

    // Bus answer one cycle after the request
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            ack_ff <= 1'b0;
            rdat_ff <= 32'h00000000;
        end
        else
        begin
            ack_ff <= req;
            rdat_ff <= req ? rd_mux : 32'h00000000;
        end
    end

    // Clock gates: registers rule in run, sleep states override
    wire run_like = (state_ff == ST_RUN);
    // CPU waits until the sleep gates have reopened; costs one cycle on a plain wake
    wire cpu_go = (nxt_state == ST_RUN) & ~in_pd;
    wire keep_slow = pwrctl_ff[BIT_KEEP] & (xtl == XTL_SLOW);
    osc_ctl_type osc_nxt;
    always_comb
    begin
        osc_nxt.fast_xtal_en = (xtl == XTL_FAST) & ~in_pd;
        osc_nxt.slow_xtal_en = (xtl == XTL_SLOW) & (~in_pd | keep_slow);
        osc_nxt.ext_clk_in = (xtl == XTL_EXTCLK);
        osc_nxt.fast_rc_en = pwrctl_ff[BIT_FAST_RC_OSCILLATOR] & ~in_pd;
        osc_nxt.slow_rc_en = pwrctl_ff[BIT_SLOW_RC_OSCILLATOR];
    end

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            cpu_en_ff <= 1'b1;
            div_en_ff <= 1'b1;
            isp_en_ff <= 1'b1;
            irq_ff <= 1'b0;
            fast_periph_ff <= 1'b1;
            osc_ff <= '0;
        end
        else
        begin
            cpu_en_ff <= cpu_go;
            div_en_ff <= ahbclk_ff[BIT_DIVCK] & ~in_pd;
            isp_en_ff <= ahbclk_ff[BIT_ISPCK] & ~in_pd;
            fast_periph_ff <= ~in_pd;
            irq_ff <= pwrctl_ff[BIT_WKIF] & pwrctl_ff[BIT_WKIEN];
            osc_ff <= osc_nxt;
        end
    end

    assign o_wb_dat = rdat_ff;
    assign o_wb_ack = ack_ff;
    assign o_cpu_clk_en = cpu_en_ff;
    assign o_divider_unit_clk_en = div_en_ff;
    assign o_flash_prog_clk_en = isp_en_ff;
    assign o_osc = osc_ff;
    assign o_fast_periph_clk_en = fast_periph_ff;
    assign o_wake_irq = irq_ff;

    // Checks
    property p_irq;
        @(posedge i_core_clk) disable iff (i_rst)
        (pwrctl_ff[BIT_WKIF] & pwrctl_ff[BIT_WKIEN]) |=> o_wake_irq;
    endproperty
    a_irq: assert property (p_irq) else $error("wake irq missing");

    property p_pd_entry;
        @(posedge i_core_clk) disable iff (i_rst)
        (run_like & i_sleep_req & pd_go) |=> in_pd ##1 ~o_cpu_clk_en;
    endproperty
    a_pd_entry: assert property (p_pd_entry) else $error("power-down not entered");

    property p_idle;
        @(posedge i_core_clk) disable iff (i_rst)
        (run_like & i_sleep_req & ~pd_go) |=> (state_ff == ST_IDLE) ##1 (~o_cpu_clk_en & o_osc.fast_rc_en == pwrctl_ff[BIT_FAST_RC_OSCILLATOR]);
    endproperty
    a_idle: assert property (p_idle) else $error("idle mode wrong");

    property p_arm_clear;
        @(posedge i_core_clk) disable iff (i_rst)
        wake_from_pd |=> ~pwrctl_ff[BIT_POWER_DOWN_ARM];
    endproperty
    a_arm_clear: assert property (p_arm_clear) else $error("arm bit not cleared");

    property p_flag_set;
        @(posedge i_core_clk) disable iff (i_rst)
        set_flag |=> pwrctl_ff[BIT_WKIF];
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("wake flag not set");

    property p_flag_gate;
        @(posedge i_core_clk) disable iff (i_rst)
        (~pwrctl_ff[BIT_WKIF] & ~pwrctl_ff[BIT_WKIEN] & ~$rose(pwrctl_ff[BIT_WKIEN])) |=> ~pwrctl_ff[BIT_WKIF];
    endproperty
    a_flag_gate: assert property (p_flag_gate) else $error("flag set without enable");

    property p_locked;
        @(posedge i_core_clk) disable iff (i_rst)
        (wr_pwr & ~unlocked_ff & ~wake_from_pd) |=> $stable(pwrctl_ff[BIT_WKIEN:0] & 6'h3F);
    endproperty
    a_locked: assert property (p_locked) else $error("protected bit changed while locked");

    property p_pd_fast_off;
        @(posedge i_core_clk) disable iff (i_rst)
        (in_pd ##1 in_pd) |-> (~o_osc.fast_xtal_en & ~o_osc.fast_rc_en & ~o_divider_unit_clk_en);
    endproperty
    a_pd_fast_off: assert property (p_pd_fast_off) else $error("fast clocks on in power-down");

    property p_wake_delay;
        @(posedge i_core_clk) disable iff (i_rst)
        (wake_from_pd & pwrctl_ff[BIT_WKDLY] & ~i_sysclk_from_fast_xtal) |=> ~o_cpu_clk_en [*8];
    endproperty
    a_wake_delay: assert property (p_wake_delay) else $error("cpu clock released early");

    property p_ahb_gate;
        @(posedge i_core_clk) disable iff (i_rst)
        (run_like & $past(run_like)) |=> (o_flash_prog_clk_en == $past(ahbclk_ff[BIT_ISPCK]));
    endproperty
    a_ahb_gate: assert property (p_ahb_gate) else $error("flash clock gate wrong");

    property p_wake_order;
        @(posedge i_core_clk) disable iff (i_rst)
        $rose(o_cpu_clk_en) |-> o_fast_periph_clk_en;
    endproperty
    a_wake_order: assert property (p_wake_order) else $error("cpu clock back before peripheral clocks");
endmodule : pwr_clk_ctrl

// ===== pwr_clk_pkg.sv
// Package for the power-down and clock-gating controller.
// Assumes a classic Wishbone slave with 32-bit data and one core clock.
package pwr_clk_pkg;
    localparam logic [7:0] ADDR_PWRCTL = 8'h00;
    localparam logic [7:0] ADDR_AHBCLK = 8'h04;
    localparam logic [7:0] ADDR_UNLOCK = 8'h08;
    localparam logic [7:0] ADDR_SYSCTL = 8'h0C;
    localparam logic [7:0] UNLOCK_KEY0 = 8'h59;
    localparam logic [7:0] UNLOCK_KEY1 = 8'h16;
    localparam logic [7:0] UNLOCK_KEY2 = 8'h88;
    localparam int BIT_POWER_DOWN_ARM = 7;
    localparam int BIT_WKIF = 6;
    localparam int BIT_WKIEN = 5;
    localparam int BIT_WKDLY = 4;
    localparam int BIT_SLOW_RC_OSCILLATOR = 3;
    localparam int BIT_FAST_RC_OSCILLATOR = 2;
    localparam int BIT_KEEP = 9;
    localparam int BIT_DEEP = 2;
    localparam int BIT_DIVCK = 4;
    localparam int BIT_ISPCK = 2;
    localparam logic [31:0] PWRCTL_RESET = 32'h0000001C;
    localparam logic [31:0] PWRCTL_WMASK = 32'h000002BF;
    localparam logic [31:0] AHBCLK_RESET = 32'h00000014;
    localparam logic [31:0] AHBCLK_MASK = 32'h00000014;
    localparam logic [1:0] XTL_GPIO = 2'h0;
    localparam logic [1:0] XTL_FAST = 2'h1;
    localparam logic [1:0] XTL_SLOW = 2'h2;
    localparam logic [1:0] XTL_EXTCLK = 2'h3;
    localparam int DLY_FAST_XTAL = 4096;
    localparam int DLY_FAST_RC = 256;
    localparam logic [12:0] DLY_FAST_XTAL_CNT = 13'(DLY_FAST_XTAL);
    localparam logic [12:0] DLY_FAST_RC_CNT = 13'(DLY_FAST_RC);

    typedef struct packed {
        logic [7:0] adr;
        logic [31:0] dat;
        logic [3:0] sel;
        logic we;
        logic cyc;
        logic stb;
    } wb_req_type;

    typedef struct packed {
        logic fast_xtal_en;
        logic slow_xtal_en;
        logic ext_clk_in;
        logic fast_rc_en;
        logic slow_rc_en;
    } osc_ctl_type;

    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_IDLE = 2'b01,
        ST_PDOWN = 2'b11,
        ST_WAKE = 2'b10
    } pm_state_type;
endpackage : pwr_clk_pkg

// ===== core_model.sv
// Behavioural model of the processor core that sleeps and of the wake sources.
// Assumes the controller samples both pulses on the rising clock edge.
module core_model
(
    input wire logic i_core_clk,
    output logic o_sleep_req,
    output logic o_wake_evt
);
    timeunit 1ns;
    timeprecision 1ps;

    // Both lines idle low from time zero
    initial o_sleep_req = 1'b0;
    initial o_wake_evt = 1'b0;

    // Wait instruction: one-cycle pulse, as the core retires it once
    task sleep_now();
        @(posedge i_core_clk);
        o_sleep_req <= 1'b1;
        @(posedge i_core_clk);
        o_sleep_req <= 1'b0;
    endtask : sleep_now

    // Any wake source: a short pulse is the harder case for the flag
    task wake_now();
        @(posedge i_core_clk);
        o_wake_evt <= 1'b1;
        @(posedge i_core_clk);
        o_wake_evt <= 1'b0;
    endtask : wake_now
endmodule : core_model

// ===== power_down_and_ahb_clock_gating_tb_top.sv
// Self-checking bench for the power-down and clock-gating controller.
// Assumes a classic Wishbone slave with one-cycle ack and the core model beside it.
module power_down_and_ahb_clock_gating_tb_top
    import pwr_clk_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic rst = 1'b1;
    wb_req_type wb = '0;
    logic [31:0] rdat;
    logic ack;
    logic sleep_req;
    logic wake_evt;
    logic from_xtal = 1'b0;
    logic cpu_en;
    logic div_en;
    logic flash_en;
    osc_ctl_type osc;
    logic fper_en;
    logic irq;
    int num_errors = 0;
    int n_tests = 0;
    logic [31:0] osc_wr [6] = '{32'h0000000C, 32'h0000000D, 32'h0000000E, 32'h0000000F, 32'h00000008, 32'h00000004};
    logic [4:0] osc_exp [6] = '{5'h03, 5'h13, 5'h0B, 5'h07, 5'h01, 5'h02};

    // Core clock, 100 MHz
    always #5 clk = ~clk;

    pwr_clk_ctrl dut_u (.i_core_clk(clk), .i_rst(rst), .i_wb(wb), .o_wb_dat(rdat), .o_wb_ack(ack),
        .i_sleep_req(sleep_req), .i_wake_evt(wake_evt), .i_sysclk_from_fast_xtal(from_xtal),
        .o_cpu_clk_en(cpu_en), .o_divider_unit_clk_en(div_en), .o_flash_prog_clk_en(flash_en),
        .o_osc(osc), .o_fast_periph_clk_en(fper_en), .o_wake_irq(irq));

    core_model core_u (.i_core_clk(clk), .o_sleep_req(sleep_req), .o_wake_evt(wake_evt));

    task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        n_tests++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk

    task close_out();
        $display("errors %0d checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : close_out

    // One classic cycle; request held until ack is sampled high
    task xfer(input logic [7:0] a, input logic [31:0] d, input logic w, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk);
        wb <= '{adr: a, dat: d, sel: 4'hF, we: w, cyc: 1'b1, stb: 1'b1};
        do
        begin
            @(posedge clk);
            n++;
        end
        while (ack !== 1'b1);
        r = rdat;
        wb <= '0;
        // Slave answers one cycle after taking; a lost answer is left to the watchdog
        chk(32'(n), 32'h2, "ack latency");
    endtask : xfer

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        xfer(a, d, 1'b1, r);
    endtask : wr

    task rdc(input logic [7:0] a, input logic [31:0] exp, input string msg);
        logic [31:0] r;
        xfer(a, 32'h0, 1'b0, r);
        chk(r, exp, msg);
    endtask : rdc

    task settle();
        repeat (3) @(posedge clk);
    endtask : settle

    // Wake from power-down and count cycles until the CPU clock returns
    task pd_wake(input int n);
        int cnt;
        cnt = 0;
        core_u.wake_now();
        while (cpu_en !== 1'b1 && cnt < 5000)
        begin
            @(posedge clk);
            cnt++;
        end
        chk(32'(cnt >= n - 1 && cnt <= n + 2), 32'h1, "wake delay");
        chk(32'(fper_en), 32'h1, "clocks before cpu");
    endtask : pd_wake

    // Hang guard, well beyond the two wake delays
    initial
    begin
        #200000;
        num_errors++;
        close_out();
    end

    // Main sequence
    initial
    begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rdc(8'h00, 32'h0000001C, "pwrctl reset");
        rdc(8'h04, 32'h00000014, "ahb reset");
        chk(32'(osc), 32'h3, "osc reset");
        wr(8'h00, 32'h00000000);
        rdc(8'h00, 32'h0000001C, "locked write");
        rdc(8'h10, 32'h00000000, "unmapped");
        wr(8'h08, 32'h00000059);
        wr(8'h08, 32'h00000016);
        wr(8'h08, 32'h00000088);
        rdc(8'h08, 32'h00000001, "unlocked");
        for (int i = 0; i < 6; i++)
        begin
            wr(8'h00, osc_wr[i]);
            settle();
            chk(32'(osc), 32'(osc_exp[i]), "osc enables");
        end
        wr(8'h04, 32'h00000010);
        settle();
        chk(32'({div_en, flash_en}), 32'h2, "divider gate");
        wr(8'h04, 32'h00000004);
        settle();
        chk(32'({div_en, flash_en}), 32'h1, "flash gate");
        wr(8'h04, 32'h00000014);
        // Deep sleep set but arm clear: still only idle
        wr(8'h00, 32'h0000000C);
        wr(8'h0C, 32'h00000004);
        core_u.sleep_now();
        settle();
        chk(32'({cpu_en, fper_en, div_en, flash_en}), 32'h7, "idle gates");
        core_u.wake_now();
        settle();
        chk(32'({cpu_en, fper_en, div_en, flash_en}), 32'hF, "run gates");
        // Enable the wake interrupt before arming
        wr(8'h00, 32'h0000023E);
        wr(8'h00, 32'h000002BE);
        core_u.sleep_now();
        settle();
        chk(32'({cpu_en, fper_en, div_en, flash_en}), 32'h0, "pd gates");
        chk(32'(osc), 32'h9, "pd osc keep slow");
        pd_wake(256);
        chk(32'(irq), 32'h1, "wake irq");
        rdc(8'h00, 32'h0000027E, "flag set arm clear");
        wr(8'h00, 32'h0000023E);
        rdc(8'h00, 32'h0000027E, "zero keeps flag");
        wr(8'h00, 32'h0000027E);
        rdc(8'h00, 32'h0000023E, "one clears flag");
        chk(32'(irq), 32'h0, "irq cleared");
        // Fast crystal, no wake interrupt enable
        from_xtal <= 1'b1;
        wr(8'h00, 32'h0000009D);
        core_u.sleep_now();
        settle();
        chk(32'(osc), 32'h1, "pd osc");
        pd_wake(4096);
        rdc(8'h00, 32'h0000001D, "flag held off");
        chk(32'(irq), 32'h0, "no irq");
        // No wake delay: peripheral clocks and the CPU come back together
        wr(8'h00, 32'h0000008D);
        core_u.sleep_now();
        settle();
        chk(32'({cpu_en, fper_en}), 32'h0, "pd no delay");
        pd_wake(1);
        rdc(8'h00, 32'h0000000D, "arm clear no delay");
        // A wrong key byte closes the lock again
        wr(8'h08, 32'h00000059);
        wr(8'h08, 32'h00000088);
        rdc(8'h08, 32'h00000000, "relocked");
        wr(8'h00, 32'h0000000C);
        rdc(8'h00, 32'h0000000D, "relocked write");
        wr(8'h04, 32'h00000000);
        settle();
        chk(32'({div_en, flash_en}), 32'h0, "both gates off");
        // Reset in mid-run restores every register and closes the lock
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rdc(8'h00, 32'h0000001C, "pwrctl after reset");
        rdc(8'h04, 32'h00000014, "ahb after reset");
        rdc(8'h08, 32'h00000000, "lock after reset");
        rdc(8'h0C, 32'h00000000, "deep after reset");
        chk(32'({div_en, flash_en, osc}), 32'h63, "gates after reset");
        close_out();
    end
endmodule : power_down_and_ahb_clock_gating_tb_top
